// ---- verilog/tcs_consts.svh ----
`ifndef TCS_CONSTS_SVH
`define TCS_CONSTS_SVH
// register byte offsets
`define TCS_OFF_CTRL 8'h00
`define TCS_OFF_STAT 8'h04
`define TCS_OFF_THR 8'h08
`define TCS_OFF_OUT 8'h0C
`define TCS_OFF_VOLT0 8'h10
`define TCS_OFF_VOLT1 8'h14
`define TCS_OFF_TEMP0 8'h18
`define TCS_OFF_TEMP1 8'h1C
`define TCS_OFF_TEMP2 8'h20
// status field positions: warn[5:0], shutdown[5:0] at 8, secondary at 16
`define TCS_ST_WARN 0
`define TCS_ST_SD 8
`define TCS_ST_SD2 16
// code thresholds; code = (350 - T) / 0.488, lower code = hotter
`define TCS_THR_WARN_RST 10'h0FF
`define TCS_THR_SD_RST 10'h0E0
// filter time and converter figures
`define TCS_FILT_US 32
`define TCS_CLK_MHZ 100
`define TCS_ADC_DIV 4
`define TCS_SAR_CYC 12
`define TCS_NCH 9
`endif

// ---- verilog/tcs_pkg.sv ----
package tcs_pkg;
    typedef enum logic [1:0] {TCS_SAMPLE, TCS_CONV, TCS_DONE} tcs_adc_e;
    typedef logic [9:0] tcs_code_t;
endpackage : tcs_pkg

// ---- verilog/tcs_adc_seq.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tcs_consts.svh"
module tcs_adc_seq #(
    parameter int NCH = `TCS_NCH,
    parameter int SAR_CYC = `TCS_SAR_CYC
) (
    input wire logic aclk, // system clock
    input wire logic aresetn, // sync reset, low
    input wire logic adc_enable, // run the converter
    input wire logic [9:0] adc_code_in, // converter output code
    output logic [3:0] adc_sel, // mux channel
    output logic adc_strobe, // one-cycle result valid
    output logic [3:0] adc_ch, // channel of result
    output logic [9:0] adc_result // converted code
);
    import tcs_pkg::*;
    initial begin
        if (NCH != 9 || SAR_CYC < 1 || SAR_CYC > 15) $error("tcs_adc_seq bad params");
    end
    logic [1:0] div_r, div_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [3:0] sel_r, sel_nxt;
    logic strobe_r, strobe_nxt;
    logic [9:0] res_r, res_nxt;
    logic [3:0] ch_r, ch_nxt;
    tcs_adc_e st_r, st_nxt;
    wire logic tick = (div_r == 2'(`TCS_ADC_DIV - 1)); // converter clock, main / 4
    always_comb begin
        div_nxt = div_r + 2'h1;
        bit_nxt = bit_r;
        sel_nxt = sel_r;
        strobe_nxt = 1'b0;
        res_nxt = res_r;
        ch_nxt = ch_r;
        st_nxt = st_r;
        if (!adc_enable) begin
            st_nxt = TCS_SAMPLE;
            bit_nxt = 4'h0;
        end else if (tick) begin
            case (st_r)
                TCS_SAMPLE: begin
                    st_nxt = TCS_CONV;
                    bit_nxt = 4'h0;
                end
                TCS_CONV: begin
                    bit_nxt = bit_r + 4'h1;
                    if (bit_r == 4'(SAR_CYC - 1)) st_nxt = TCS_DONE;
                end
                TCS_DONE: begin
                    // one conversion time per channel, nine channels in turn
                    strobe_nxt = 1'b1;
                    res_nxt = adc_code_in;
                    ch_nxt = sel_r;
                    sel_nxt = (sel_r == 4'(NCH - 1)) ? 4'h0 : sel_r + 4'h1;
                    st_nxt = TCS_SAMPLE;
                end
                default: st_nxt = TCS_SAMPLE;
            endcase
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_r <= 2'h0;
            bit_r <= 4'h0;
            sel_r <= 4'h0;
            strobe_r <= 1'b0;
            res_r <= 10'h000;
            ch_r <= 4'h0;
            st_r <= TCS_SAMPLE;
        end else begin
            div_r <= div_nxt;
            bit_r <= bit_nxt;
            sel_r <= sel_nxt;
            strobe_r <= strobe_nxt;
            res_r <= res_nxt;
            ch_r <= ch_nxt;
            st_r <= st_nxt;
        end
    end
    assign adc_sel = sel_r;
    assign adc_strobe = strobe_r;
    assign adc_ch = ch_r;
    assign adc_result = res_r;
    a_chan_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
        adc_strobe |-> adc_ch < 4'(NCH)) else $error("channel out of range");
    a_strobe_space: assert property (@(posedge aclk) disable iff (!aresetn)
        adc_strobe |=> !adc_strobe [*8]) else $error("results too close");
endmodule : tcs_adc_seq
`default_nettype wire

// ---- verilog/tcs_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tcs_consts.svh"
module tcs_top #(
    parameter int NCL = 6,
    parameter int FILT_CYC = `TCS_FILT_US * `TCS_CLK_MHZ
) (
    input wire logic aclk, // 100 MHz clock
    input wire logic aresetn, // sync reset, low
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read valid
    input wire logic s_axi_rready, // read ready
    input wire logic [9:0] adc_code_in, // converter code
    output logic [3:0] adc_sel, // converter mux select
    input wire logic reg_primary_thermal_shutdown_cmp, // regulator cluster primary comparator
    input wire logic reg_secondary_thermal_shutdown_cmp, // regulator cluster secondary comparator
    input wire logic glb_primary_thermal_shutdown_cmp, // global cluster primary comparator
    output logic [5:0] cluster_out_en, // per-cluster output stage enable
    output logic main_regulator_en, // main regulator enable
    output logic gate_discharge_rl // gate drivers resistive low
);
    import tcs_pkg::*;
    initial begin
        if (NCL != 6 || FILT_CYC < 1 || FILT_CYC > 65535) $error("tcs_top bad params");
    end

    logic adc_strobe;
    logic [3:0] adc_ch;
    tcs_code_t adc_result;
    logic [3:0] adc_sel_w;

    tcs_adc_seq #(.NCH(`TCS_NCH), .SAR_CYC(`TCS_SAR_CYC)) u_adc (
        .aclk(aclk),
        .aresetn(aresetn),
        .adc_enable(1'b1),
        .adc_code_in(adc_code_in),
        .adc_sel(adc_sel_w),
        .adc_strobe(adc_strobe),
        .adc_ch(adc_ch),
        .adc_result(adc_result)
    );

    // register state
    logic policy_r, policy_nxt; // cluster_policy_select: 0 standard, 1 cluster
    tcs_code_t thr_warn_r, thr_warn_nxt;
    tcs_code_t thr_sd_r, thr_sd_nxt;
    tcs_code_t volt_r [3], volt_nxt [3];
    tcs_code_t temp_r [6], temp_nxt [6];
    logic [5:0] warn_r, warn_nxt;
    logic [5:0] sd_r, sd_nxt;
    logic sd2_r, sd2_nxt;
    logic [15:0] wcnt_r [6], wcnt_nxt [6];
    logic [15:0] scnt_r [6], scnt_nxt [6];
    logic [5:0] out_en_r, out_en_nxt;
    logic reg_en_r, reg_en_nxt;
    logic rl_r, rl_nxt;
    logic [3:0] sel_r;

    // axi state
    logic awhave_r, awhave_nxt, whave_r, whave_nxt;
    logic [7:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;

    logic [5:0] over_warn, over_sd, warn_set, sd_set, sd_clr, warn_clr;
    logic wr_go;
    logic [31:0] stat_word;

    assign wr_go = awhave_r && whave_r && !bvalid_r;
    assign stat_word = {15'h0000, sd2_r, 2'h0, sd_r, 2'h0, warn_r};

    // per-cluster judging and filtering
    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_cl
            // lower code means hotter
            assign over_warn[g] = temp_r[g] < thr_warn_r;
            if (g < 4) begin : g_dig
                assign over_sd[g] = temp_r[g] < thr_sd_r;
            end else if (g == 4) begin : g_reg
                assign over_sd[g] = reg_primary_thermal_shutdown_cmp;
            end else begin : g_glb
                assign over_sd[g] = glb_primary_thermal_shutdown_cmp;
            end
            always_comb begin
                wcnt_nxt[g] = over_warn[g] ? wcnt_r[g] : 16'h0000;
                if (over_warn[g] && wcnt_r[g] != 16'(FILT_CYC)) wcnt_nxt[g] = wcnt_r[g] + 16'h1;
                // a clear restarts the filter, so a still-hot cluster waits a full time
                if (warn_clr[g] && !warn_set[g]) wcnt_nxt[g] = 16'h0000;
                // shutdown filter starts once the warning stands, giving two filters
                scnt_nxt[g] = (over_sd[g] && warn_r[g]) ? scnt_r[g] : 16'h0000;
                if (over_sd[g] && warn_r[g] && scnt_r[g] != 16'(FILT_CYC))
                    scnt_nxt[g] = scnt_r[g] + 16'h1;
                if (sd_clr[g] && !sd_set[g]) scnt_nxt[g] = 16'h0000;
            end
            // one pulse as the filter fills; a saturated count must not block a clear
            assign warn_set[g] = over_warn[g] && wcnt_r[g] == 16'(FILT_CYC - 1);
            assign sd_set[g] = over_sd[g] && warn_r[g] &&
                scnt_r[g] == 16'(FILT_CYC - 1);
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    wcnt_r[g] <= 16'h0000;
                    scnt_r[g] <= 16'h0000;
                end else begin
                    wcnt_r[g] <= wcnt_nxt[g];
                    scnt_r[g] <= scnt_nxt[g];
                end
            end
        end
    endgenerate

    // clear from a status write: only bits written one
    always_comb begin
        warn_clr = 6'h00;
        sd_clr = 6'h00;
        if (wr_go && awaddr_r == `TCS_OFF_STAT && wstrb_r[0])
            warn_clr = wdata_r[`TCS_ST_WARN +: 6];
        if (wr_go && awaddr_r == `TCS_OFF_STAT && wstrb_r[1])
            sd_clr = wdata_r[`TCS_ST_SD +: 6];
    end

    always_comb begin
        policy_nxt = policy_r;
        thr_warn_nxt = thr_warn_r;
        thr_sd_nxt = thr_sd_r;
        volt_nxt = volt_r;
        temp_nxt = temp_r;
        // sticky: set wins over a clear in the same cycle
        warn_nxt = (warn_r & ~warn_clr) | warn_set;
        sd_nxt = (sd_r & ~sd_clr) | sd_set;
        sd2_nxt = sd2_r | reg_secondary_thermal_shutdown_cmp;
        if (wr_go && awaddr_r == `TCS_OFF_STAT && wstrb_r[2] && wdata_r[`TCS_ST_SD2] &&
            !reg_secondary_thermal_shutdown_cmp)
            sd2_nxt = 1'b0;
        if (adc_strobe) begin
            if (adc_ch < 4'h3) volt_nxt[adc_ch[1:0]] = adc_result;
            else temp_nxt[3'(adc_ch - 4'h3)] = adc_result;
        end
        if (wr_go && awaddr_r == `TCS_OFF_CTRL && wstrb_r[0]) policy_nxt = wdata_r[0];
        if (wr_go && awaddr_r == `TCS_OFF_THR) begin
            if (wstrb_r[0]) thr_warn_nxt[7:0] = wdata_r[7:0];
            if (wstrb_r[1]) thr_warn_nxt[9:8] = wdata_r[9:8];
            if (wstrb_r[2]) thr_sd_nxt[7:0] = wdata_r[23:16];
            if (wstrb_r[3]) thr_sd_nxt[9:8] = wdata_r[25:24];
        end
        // output policy from the held flags, so clearing reactivates
        if (sd_r[5] || sd_r[4]) begin
            out_en_nxt = 6'h00;
        end else if (sd_r != 6'h00 && !policy_r) begin
            out_en_nxt = 6'h00;
        end else begin
            out_en_nxt = ~sd_r;
        end
        reg_en_nxt = !sd2_r;
        rl_nxt = sd_r != 6'h00;
    end

    // axi-lite slave: aw and w in either order, one write and one read at a time
    always_comb begin
        awhave_nxt = awhave_r;
        whave_nxt = whave_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (s_axi_awvalid && !awhave_r) begin
            awhave_nxt = 1'b1;
            awaddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && !whave_r) begin
            whave_nxt = 1'b1;
            wdata_nxt = s_axi_wdata;
            wstrb_nxt = s_axi_wstrb;
        end
        if (wr_go) begin
            bvalid_nxt = 1'b1;
            bresp_nxt = (awaddr_r == `TCS_OFF_CTRL || awaddr_r == `TCS_OFF_STAT ||
                awaddr_r == `TCS_OFF_THR) ? 2'h0 : 2'h2;
            awhave_nxt = 1'b0;
            whave_nxt = 1'b0;
        end
        if (bvalid_r && s_axi_bready) bvalid_nxt = 1'b0;
        if (rvalid_r && s_axi_rready) rvalid_nxt = 1'b0;
        if (s_axi_arvalid && !rvalid_r) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = 2'h0;
            case (s_axi_araddr)
                `TCS_OFF_CTRL: rdata_nxt = {31'h00000000, policy_r};
                `TCS_OFF_STAT: rdata_nxt = stat_word;
                `TCS_OFF_THR: rdata_nxt = {6'h00, thr_sd_r, 6'h00, thr_warn_r};
                `TCS_OFF_OUT: rdata_nxt = {24'h000000, rl_r, reg_en_r, out_en_r};
                `TCS_OFF_VOLT0: rdata_nxt = {6'h00, volt_r[1], 6'h00, volt_r[0]};
                `TCS_OFF_VOLT1: rdata_nxt = {22'h000000, volt_r[2]};
                // cluster temperature codes
                `TCS_OFF_TEMP0: rdata_nxt = {6'h00, temp_r[1], 6'h00, temp_r[0]};
                `TCS_OFF_TEMP1: rdata_nxt = {6'h00, temp_r[3], 6'h00, temp_r[2]};
                `TCS_OFF_TEMP2: rdata_nxt = {6'h00, temp_r[5], 6'h00, temp_r[4]};
                default: begin
                    rdata_nxt = 32'h00000000;
                    rresp_nxt = 2'h2;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            policy_r <= 1'b0;
            thr_warn_r <= `TCS_THR_WARN_RST;
            thr_sd_r <= `TCS_THR_SD_RST;
            for (int i = 0; i < 3; i++) volt_r[i] <= 10'h000;
            for (int i = 0; i < 6; i++) temp_r[i] <= 10'h3FF;
            warn_r <= 6'h00;
            sd_r <= 6'h00;
            sd2_r <= 1'b0;
            out_en_r <= 6'h3F;
            reg_en_r <= 1'b1;
            rl_r <= 1'b0;
            sel_r <= 4'h0;
            awhave_r <= 1'b0;
            whave_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= 2'h0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= 2'h0;
        end else begin
            policy_r <= policy_nxt;
            thr_warn_r <= thr_warn_nxt;
            thr_sd_r <= thr_sd_nxt;
            volt_r <= volt_nxt;
            temp_r <= temp_nxt;
            warn_r <= warn_nxt;
            sd_r <= sd_nxt;
            sd2_r <= sd2_nxt;
            out_en_r <= out_en_nxt;
            reg_en_r <= reg_en_nxt;
            rl_r <= rl_nxt;
            sel_r <= adc_sel_w;
            awhave_r <= awhave_nxt;
            whave_r <= whave_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    assign s_axi_awready = !awhave_r;
    assign s_axi_wready = !whave_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign adc_sel = sel_r;
    assign cluster_out_en = out_en_r;
    assign main_regulator_en = reg_en_r;
    assign gate_discharge_rl = rl_r;

    sequence s_warn_held;
        warn_r[0] && !warn_clr[0];
    endsequence
    a_warn_sets: assert property (@(posedge aclk) disable iff (!aresetn)
        warn_set[0] |=> warn_r[0]) else $error("warning not set");
    a_sd_sets: assert property (@(posedge aclk) disable iff (!aresetn)
        sd_set[0] |=> sd_r[0]) else $error("shutdown not set");
    a_sd_needs_warn: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(sd_r[0]) |-> $past(warn_r[0])) else $error("shutdown before warning");
    a_rl_follows: assert property (@(posedge aclk) disable iff (!aresetn)
        (sd_r != 6'h00) |=> gate_discharge_rl) else $error("no resistive low");
    a_global_off: assert property (@(posedge aclk) disable iff (!aresetn)
        sd_r[5] |=> cluster_out_en == 6'h00) else $error("global shutdown leaks");
    a_std_off: assert property (@(posedge aclk) disable iff (!aresetn)
        (!policy_r && sd_r != 6'h00) |=> cluster_out_en == 6'h00) else $error("std leak");
    a_cl_only: assert property (@(posedge aclk) disable iff (!aresetn)
        (policy_r && sd_r[3:0] == 4'h2 && sd_r[5:4] == 2'h0) |=> cluster_out_en == 6'h3D)
        else $error("cluster mode wrong");
    a_reactivate: assert property (@(posedge aclk) disable iff (!aresetn)
        (sd_r == 6'h00) |=> cluster_out_en == 6'h3F) else $error("not reactivated");
    a_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        s_warn_held |=> warn_r[0]) else $error("flag dropped");
    a_clear_bits: assert property (@(posedge aclk) disable iff (!aresetn)
        (sd_clr[1] && !sd_set[1]) |=> !sd_r[1]) else $error("clear ignored");
endmodule : tcs_top
`default_nettype wire

// ---- tb/tcs_adc_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module tcs_adc_model (
    input wire logic [3:0] adc_sel, // channel chosen by the block
    input wire logic [89:0] codes, // ten-bit code per channel, channel 0 lowest
    output logic [9:0] adc_code_in // converter result
);
    // unused mux settings toggle, so a stale code never looks valid
    always_comb begin
        if (adc_sel < 4'h9) begin
            adc_code_in = codes[adc_sel * 10 +: 10];
        end else begin
            adc_code_in = {5{~adc_sel[0], adc_sel[0]}};
        end
    end
endmodule : tcs_adc_model
`default_nettype wire

// ---- tb/test_thermal_cluster_supervisor.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tcs_consts.svh"
module test_thermal_cluster_supervisor;
    localparam int FILT = 4;
    localparam logic [9:0] HOT = 10'h0A0;
    localparam logic [9:0] COLD = 10'h29A;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, main_regulator_en, gate_discharge_rl;
    logic reg_primary_thermal_shutdown_cmp, reg_secondary_thermal_shutdown_cmp, glb_primary_thermal_shutdown_cmp;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, adc_sel;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [9:0] adc_code_in;
    logic [5:0] cluster_out_en;
    logic [89:0] codes;
    int fail_count, checks_done;

    tcs_top #(.FILT_CYC(FILT)) dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .adc_code_in, .adc_sel, .reg_primary_thermal_shutdown_cmp, .reg_secondary_thermal_shutdown_cmp, .glb_primary_thermal_shutdown_cmp,
        .cluster_out_en, .main_regulator_en, .gate_discharge_rl);
    tcs_adc_model adc_u (.adc_sel, .codes, .adc_code_in);

    task automatic summarize;
        if (fail_count == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize

    task automatic give_up(input string nm);
        fail_count++;
        $display("MISMATCH %s expected done seen timeout", nm);
        summarize();
    endtask : give_up

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) begin
                s_axi_bready <= 1'b0;
                r = s_axi_bresp;
                break;
            end
        end
        if (n == 50) give_up("write response");
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) begin
                s_axi_rready <= 1'b0;
                d = s_axi_rdata;
                r = s_axi_rresp;
                break;
            end
        end
        if (n == 50) give_up("read data");
    endtask : axi_rd

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        chk(nm, exp, d);
    endtask : rd_chk

    task automatic wait_stat(input logic [31:0] m);
        logic [31:0] d;
        logic [1:0] r;
        int n;
        for (n = 0; n < 400; n++) begin
            axi_rd(`TCS_OFF_STAT, d, r);
            if ((d & m) === m) break;
        end
        if (n == 400) give_up("status flags");
    endtask : wait_stat

    task automatic set_code(input int ch, input logic [9:0] v);
        codes[ch * 10 +: 10] <= v;
    endtask : set_code

    task automatic outs_chk(input logic [5:0] en, input logic reg_en, input logic rl);
        chk("cluster enables", {26'h0, en}, {26'h0, cluster_out_en});
        chk("regulator enable", {31'h0, reg_en}, {31'h0, main_regulator_en});
        chk("gate discharge", {31'h0, rl}, {31'h0, gate_discharge_rl});
    endtask : outs_chk

    function automatic logic [9:0] code_of(input real t);
        code_of = 10'($rtoi((350.0 - t) / 0.488 + 0.5));
    endfunction : code_of

    task automatic check_reset;
        logic [31:0] d;
        logic [1:0] r;
        rd_chk("ctrl", `TCS_OFF_CTRL, 32'h0);
        rd_chk("thresholds", `TCS_OFF_THR, 32'h00E000FF);
        rd_chk("out state", `TCS_OFF_OUT, 32'h7F);
        rd_chk("status", `TCS_OFF_STAT, 32'h0);
        axi_rd(8'h40, d, r);
        chk("unmapped resp", 32'h2, {30'h0, r});
        axi_wr(`TCS_OFF_VOLT0, 32'h1, r);
        chk("read-only resp", 32'h2, {30'h0, r});
        axi_wr(`TCS_OFF_THR, 32'h00C00100, r);
        chk("thr resp", 32'h0, {30'h0, r});
        rd_chk("thr write", `TCS_OFF_THR, 32'h00C00100);
        axi_wr(`TCS_OFF_THR, 32'h00E000FF, r);
    endtask : check_reset

    task automatic check_sequencer;
        logic [3:0] s;
        int n;
        s = adc_sel;
        for (n = 0; n < 200 && adc_sel === s; n++) @(posedge aclk);
        s = adc_sel;
        for (n = 0; n < 200 && adc_sel === s; n++) @(posedge aclk);
        chk("slot length", 32'h38, 32'(n));
        chk("next channel", {28'h0, (s == 4'h8) ? 4'h0 : s + 4'h1}, {28'h0, adc_sel});
    endtask : check_sequencer

    task automatic check_standard;
        logic [1:0] r;
        int n;
        set_code(3, HOT);
        wait_stat(32'h101);
        @(posedge aclk);
        #1 outs_chk(6'h00, 1'b1, 1'b1);
        // clearing while still hot must give the outputs back for a while
        axi_wr(`TCS_OFF_STAT, 32'h101, r);
        #1 outs_chk(6'h3F, 1'b1, 1'b0);
        for (n = 0; n < 100 && cluster_out_en !== 6'h00; n++) @(posedge aclk);
        chk("refire delay ok", 32'h1, {31'h0, n >= 2 * FILT && n < 100});
        set_code(3, COLD);
        repeat (1100) @(posedge aclk);
        rd_chk("flags held", `TCS_OFF_STAT, 32'h101);
        axi_wr(`TCS_OFF_STAT, 32'h001, r);
        rd_chk("partial clear", `TCS_OFF_STAT, 32'h100);
        axi_wr(`TCS_OFF_STAT, 32'h100, r);
        #1 outs_chk(6'h3F, 1'b1, 1'b0);
        rd_chk("status clear", `TCS_OFF_STAT, 32'h0);
    endtask : check_standard

    task automatic check_cluster;
        logic [1:0] r;
        axi_wr(`TCS_OFF_CTRL, 32'h1, r);
        set_code(4, HOT);
        wait_stat(32'h202);
        @(posedge aclk);
        #1 outs_chk(6'h3D, 1'b1, 1'b1);
        set_code(4, COLD);
        repeat (1100) @(posedge aclk);
        axi_wr(`TCS_OFF_STAT, 32'h202, r);
        #1 outs_chk(6'h3F, 1'b1, 1'b0);
    endtask : check_cluster

    task automatic check_analog;
        logic [1:0] r;
        set_code(8, HOT);
        wait_stat(32'h20);
        repeat (20) @(posedge aclk);
        // hot code alone must not trip the comparator-managed global group
        rd_chk("warn only", `TCS_OFF_STAT, 32'h20);
        glb_primary_thermal_shutdown_cmp <= 1'b1;
        wait_stat(32'h2020);
        @(posedge aclk);
        #1 outs_chk(6'h00, 1'b1, 1'b1);
        set_code(7, HOT);
        reg_primary_thermal_shutdown_cmp <= 1'b1;
        reg_secondary_thermal_shutdown_cmp <= 1'b1;
        wait_stat(32'h11010);
        @(posedge aclk);
        #1 outs_chk(6'h00, 1'b0, 1'b1);
        glb_primary_thermal_shutdown_cmp <= 1'b0;
        reg_primary_thermal_shutdown_cmp <= 1'b0;
        reg_secondary_thermal_shutdown_cmp <= 1'b0;
        set_code(7, COLD);
        set_code(8, COLD);
        repeat (1100) @(posedge aclk);
        axi_wr(`TCS_OFF_STAT, 32'h13030, r);
        #1 outs_chk(6'h3F, 1'b1, 1'b0);
        axi_wr(`TCS_OFF_CTRL, 32'h0, r);
    endtask : check_analog

    task automatic check_readout;
        set_code(0, 10'h123);
        set_code(1, 10'h2AB);
        set_code(2, 10'h05A);
        set_code(3, code_of(-40.0));
        set_code(4, code_of(25.0));
        repeat (1100) @(posedge aclk);
        rd_chk("volt0", `TCS_OFF_VOLT0, 32'h02AB0123);
        rd_chk("volt1", `TCS_OFF_VOLT1, 32'h0000005A);
        rd_chk("temp0", `TCS_OFF_TEMP0, {6'h0, code_of(25.0), 6'h0, code_of(-40.0)});
        // host side filtering: the same code over three successive refreshes
        for (int k = 0; k < 3; k++) begin
            repeat (510) @(posedge aclk);
            rd_chk("temp0 repeat", `TCS_OFF_TEMP0, {6'h0, code_of(25.0), 6'h0, code_of(-40.0)});
        end
    endtask : check_readout

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    initial begin
        repeat (100000) @(posedge aclk);
        give_up("whole run");
    end

    initial begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {reg_primary_thermal_shutdown_cmp, reg_secondary_thermal_shutdown_cmp, glb_primary_thermal_shutdown_cmp} = 3'h0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        codes = {9{COLD}};
        fail_count = 0;
        checks_done = 0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        check_reset();
        check_sequencer();
        check_standard();
        check_cluster();
        check_analog();
        check_readout();
        summarize();
    end
endmodule : test_thermal_cluster_supervisor
`default_nettype wire
